// *** src/sdm_pkg.sv ***
// Purpose: Shared constants and types for the supervisory frame sync demultiplexer.
// Assumes: Timing is counted in rising edges of the reference square wave.
// Notes:   One bit period is a fixed number of reference cycles.
package sdm_pkg;

	// Frame layout, in bit positions counted from one.
	localparam int unsigned NUM_TRUNKS      = 6;
	localparam int unsigned BITS_PER_FRAME  = 9;
	localparam int unsigned TROUBLE_POS     = 3;
	localparam int unsigned FIRST_TRUNK_POS = 4;

	// Reference timing.
	localparam int unsigned REF_HZ_X10      = 38200;
	localparam int unsigned BIT_RATE_X10    = 955;
	localparam int unsigned REF_PER_BIT     = REF_HZ_X10 / BIT_RATE_X10;
	localparam int unsigned CNT_W           = 9;

	// Frame clock marks, measured from the first to second sync bit transition.
	localparam logic [CNT_W-1:0] PREP_AT    = 9'(8 * REF_PER_BIT);
	localparam logic [CNT_W-1:0] APER_HALF  = 9'(REF_PER_BIT / 4);
	localparam logic [CNT_W-1:0] FRAME_LEN  = 9'((BITS_PER_FRAME) * REF_PER_BIT);
	localparam logic [CNT_W-1:0] APER_OPEN  = FRAME_LEN - APER_HALF;
	localparam logic [CNT_W-1:0] APER_CLOSE = FRAME_LEN + APER_HALF;
	localparam logic [CNT_W-1:0] HALF_BIT   = 9'(REF_PER_BIT / 2);

	// Sample points: midpoint of a bit at a given frame position.
	function automatic logic [CNT_W-1:0] mid_of(input int unsigned pos);
		mid_of = 9'((pos - 2) * REF_PER_BIT + REF_PER_BIT / 2);
	endfunction

	// Frame clock states.
	typedef enum logic [1:0] {
		SDM_HUNT  = 2'b01,
		SDM_TRACK = 2'b10
	} sdm_state_e;

	// Frame timing state carried as one group.
	typedef struct packed {
		sdm_state_e       state;
		logic             in_sync;
		logic             expect_rise;
		logic [CNT_W-1:0] cnt;
	} sdm_frm_s;

	localparam sdm_frm_s FRM_RESET = '{state: SDM_HUNT, in_sync: 1'b0, expect_rise: 1'b0, cnt: '0};

endpackage

// *** src/sdm_demux.sv ***
// Purpose: Acquires frame sync on the supervisory data train and latches trunk states.
// Assumes: Data and reference inputs are synchronous to clk.
// Notes:   Lamp outputs are active high; a lit trunk lamp means on-hook.
//          Sync is only declared after one full frame has been checked, so a
//          single stray transition can never light the sync lamp.
`timescale 1ns/1ps

module sdm_demux #(
	parameter int unsigned NUM_TRUNKS = sdm_pkg::NUM_TRUNKS
) (
	// Clock and reset.
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// Demodulated data train and timing reference.
	input  wire logic                  binary_train_lead,
	input  wire logic                  ref_square,
	// Indicators.
	output logic                       sync_indicator,
	output logic [NUM_TRUNKS-1:0]      trunk_state_indicators,
	output logic                       trunk_busy,
	// Event and monitor outputs.
	output logic                       sync_loss_pulse,
	output logic                       sample_strobe,
	output logic                       distortion_data_n
);

	// Input edge tracking.
	logic data_prev_r;
	logic data_prev_nxt;
	logic ref_prev_r;
	logic ref_prev_nxt;
	logic prime_r;
	logic prime_nxt;
	logic dm_r;
	logic dm_nxt;
	logic ref_tick;
	logic data_edge;
	logic data_rise;

	// Frame timing.
	sdm_pkg::sdm_frm_s frm_r;
	sdm_pkg::sdm_frm_s frm_nxt;
	logic              loss_r;
	logic              loss_nxt;
	// Phase flags of the sync test.
	logic              rec_open_r;
	logic              rec_open_nxt;
	logic              prep_r;
	logic              prep_nxt;
	logic              aper_r;
	logic              aper_nxt;

	// Trunk memory and strobes.
	logic [NUM_TRUNKS-1:0] lamp_r;
	logic [NUM_TRUNKS-1:0] trunk_hit;
	logic                  busy_r;
	logic                  busy_nxt;
	logic                  strobe_r;
	logic                  strobe_nxt;
	logic                  trouble_hit;

	// Nothing counts as an edge in the first cycle after reset, since the
	// history flops hold reset values rather than the real pin levels.
	assign ref_tick  = prime_r & ref_square & ~ref_prev_r;
	assign data_edge = prime_r & (binary_train_lead ^ data_prev_r);
	assign data_rise = prime_r & binary_train_lead & ~data_prev_r;

	// The distortion copy is a plain registered inverse, so the meter side
	// never loads the demultiplexer input.
	always_comb
	begin
		prime_nxt     = 1'b1;
		data_prev_nxt = binary_train_lead;
		ref_prev_nxt  = ref_square;
		dm_nxt        = ~binary_train_lead;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			data_prev_r <= 1'b0;
			prime_r     <= 1'b0;
			ref_prev_r  <= 1'b0;
			dm_r        <= 1'b1;
		end
		else
		begin
			data_prev_r <= data_prev_nxt;
			prime_r     <= prime_nxt;
			ref_prev_r  <= ref_prev_nxt;
			dm_r        <= dm_nxt;
		end
	end

	// Frame clock and sync decision. The count starts at the sync transition
	// and is advanced only on reference edges, so every mark is a whole
	// number of reference cycles.
	// The aperture spans a quarter bit either side of the nine-bit mark.
	always_comb
	begin
		frm_nxt  = frm_r;
		loss_nxt = 1'b0;
		case (frm_r.state)
			sdm_pkg::SDM_HUNT:
			begin
				// Any edge is taken here; a wrong guess fails the next aperture
				// and the search moves on to the following transition.
				if (rec_open_r && data_edge)
				begin
					frm_nxt.expect_rise = data_rise;
					frm_nxt.cnt         = '0;
					frm_nxt.state       = sdm_pkg::SDM_TRACK;
				end
			end
			sdm_pkg::SDM_TRACK:
			begin
				if (prep_r)
				begin
					frm_nxt.expect_rise = ~frm_r.expect_rise;
				end
				// A matching edge wins over a reference tick in the same cycle;
				// the count restarts from zero either way.
				if (aper_r && data_edge && (data_rise == frm_r.expect_rise))
				begin
					frm_nxt.in_sync = 1'b1;
					frm_nxt.cnt     = '0;
				end
				else if (ref_tick)
				begin
					// No matching edge by the end of the aperture: drop sync at once.
					if (frm_r.cnt == sdm_pkg::APER_CLOSE)
					begin
						frm_nxt.in_sync = 1'b0;
						frm_nxt.state   = sdm_pkg::SDM_HUNT;
						frm_nxt.cnt     = '0;
						// A failed recovery attempt is no loss; only a drop from in-sync pulses.
						loss_nxt        = frm_r.in_sync;
					end
					else
					begin
						frm_nxt.cnt = frm_r.cnt + 9'h001;
					end
				end
			end
			default:
			begin
				frm_nxt = sdm_pkg::FRM_RESET;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			frm_r  <= sdm_pkg::FRM_RESET;
			loss_r <= 1'b0;
		end
		else
		begin
			frm_r  <= frm_nxt;
			loss_r <= loss_nxt;
		end
	end

	// Recovery gate, preparation pulse and aperture window. The preparation
	// pulse comes one cycle after the eight-bit mark, so the expected
	// direction is flipped well before the aperture opens.
	always_comb
	begin
		rec_open_nxt = (frm_nxt.state == sdm_pkg::SDM_HUNT);
		prep_nxt     = (frm_r.state == sdm_pkg::SDM_TRACK) && ref_tick &&
			(frm_r.cnt == sdm_pkg::PREP_AT);
		aper_nxt     = (frm_nxt.state == sdm_pkg::SDM_TRACK) && (frm_nxt.cnt >= sdm_pkg::APER_OPEN) &&
			(frm_nxt.cnt <= sdm_pkg::APER_CLOSE);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rec_open_r <= 1'b1;
			prep_r     <= 1'b0;
			aper_r     <= 1'b0;
		end
		else
		begin
			rec_open_r <= rec_open_nxt;
			prep_r     <= prep_nxt;
			aper_r     <= aper_nxt;
		end
	end

	// Sample points at bit midpoints, one per trunk position.
	// Marks count from the sync transition, which opens the second bit, so
	// the trouble bit centre lies one and a half bits in.
	assign trouble_hit = (frm_r.state == sdm_pkg::SDM_TRACK) && ref_tick &&
		(frm_r.cnt == sdm_pkg::mid_of(sdm_pkg::TROUBLE_POS));

	genvar gi;
	generate
		for (gi = 0; gi < NUM_TRUNKS; gi++)
		begin : g_trunk
			// Each trunk has its own latch; a sample lands only while in sync.
			logic lamp_bit_r;
			logic lamp_bit_nxt;

			assign trunk_hit[gi] = (frm_r.state == sdm_pkg::SDM_TRACK) && ref_tick &&
				(frm_r.cnt == sdm_pkg::mid_of(sdm_pkg::FIRST_TRUNK_POS + gi));

			always_comb
			begin
				lamp_bit_nxt = lamp_bit_r;
				if (frm_r.in_sync && trunk_hit[gi])
				begin
					lamp_bit_nxt = ~binary_train_lead;
				end
			end

			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					lamp_bit_r <= 1'b0;
				end
				else
				begin
					lamp_bit_r <= lamp_bit_nxt;
				end
			end

			assign lamp_r[gi] = lamp_bit_r;
		end
	endgenerate

	always_comb
	begin
		// The trouble bit is latched like a trunk bit but not inverted; while high it asks for
		// every trunk of the far terminal to be made busy.
		busy_nxt   = busy_r;
		strobe_nxt = (|trunk_hit) & frm_r.in_sync;
		if (frm_r.in_sync)
		begin
			if (trouble_hit)
			begin
				busy_nxt = binary_train_lead;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_r   <= 1'b0;
			strobe_r <= 1'b0;
		end
		else
		begin
			busy_r   <= busy_nxt;
			strobe_r <= strobe_nxt;
		end
	end

	// Every indicator comes straight from a register, so the lamps never
	// glitch while the frame logic settles.
	assign sync_indicator         = frm_r.in_sync;
	assign trunk_state_indicators = lamp_r;
	assign trunk_busy             = busy_r;
	assign sync_loss_pulse        = loss_r;
	assign sample_strobe          = strobe_r;
	assign distortion_data_n      = dm_r;

endmodule

// *** tb/sdm_assertions.sv ***
// Purpose: Port assertions for the demultiplexer.
// Assumes: One clock domain.
// Notes:   Bound into every sdm_demux.
`timescale 1ns/1ps
module sdm_chk #(
	parameter int unsigned NUM_TRUNKS = 6
) (
	// Clock and reset.
	input wire logic                  clk,
	input wire logic                  rst_n,
	// Watched signals.
	input wire logic                  binary_train_lead,
	input wire logic                  sync_indicator,
	input wire logic [NUM_TRUNKS-1:0] trunk_state_indicators,
	input wire logic                  trunk_busy,
	input wire logic                  sync_loss_pulse,
	input wire logic                  sample_strobe,
	input wire logic                  distortion_data_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_copy; distortion_data_n == !$past(binary_train_lead); endproperty
	a_copy: assert property (p_copy) else $error("copy wrong");
	property p_loss; $fell(sync_indicator) |-> sync_loss_pulse; endproperty
	a_loss: assert property (p_loss) else $error("no loss pulse");
	property p_drop; sync_loss_pulse |-> $fell(sync_indicator); endproperty
	a_drop: assert property (p_drop) else $error("stray loss pulse");
	property p_frz; !$past(sync_indicator) |-> $stable(trunk_state_indicators) && $stable(trunk_busy); endproperty
	a_frz: assert property (p_frz) else $error("memory moved");
	property p_stb; sample_strobe |-> sync_indicator; endproperty
	a_stb: assert property (p_stb) else $error("strobe out of sync");
	property p_steer; $changed(trunk_state_indicators) |-> sample_strobe; endproperty
	a_steer: assert property (p_steer) else $error("lamp without sample");
	property p_match; $rose(sync_indicator) |-> $past(binary_train_lead) != $past(binary_train_lead, 2); endproperty
	a_match: assert property (p_match) else $error("sync without edge");
	property p_rec; $fell(sync_indicator) |=> !sync_indicator[*8]; endproperty
	a_rec: assert property (p_rec) else $error("early resync");
	property p_hold; $rose(sync_indicator) |=> sync_indicator[*8]; endproperty
	a_hold: assert property (p_hold) else $error("sync not held");
endmodule
bind sdm_demux sdm_chk #(.NUM_TRUNKS(NUM_TRUNKS)) chk_u (.clk(clk), .rst_n(rst_n),
	.binary_train_lead(binary_train_lead), .sync_indicator(sync_indicator),
	.trunk_state_indicators(trunk_state_indicators), .trunk_busy(trunk_busy), .sync_loss_pulse(sync_loss_pulse),
	.sample_strobe(sample_strobe), .distortion_data_n(distortion_data_n));

// *** tb/sdm_far_end.sv ***
// Purpose: Far terminal model sending framed supervisory data.
// Assumes: Reference period is four clocks.
// Notes:   A bad request freezes the sync pattern.
`timescale 1ns/1ps
module sdm_far_end (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Frame content.
	input  wire logic [5:0] offhk,
	input  wire logic       trbl,
	input  wire logic       bad,
	// Line outputs.
	output logic            data,
	output logic            ref_sq
);
	logic [7:0] c_r;
	logic [3:0] pos_r;
	logic [1:0] ph_r;
	logic       fa_r;
	assign ref_sq = ph_r[1];
	always_comb
	begin
		case (pos_r)
			4'h0: data = fa_r;
			4'h1: data = ~fa_r;
			4'h2: data = trbl;
			default: data = offhk[pos_r - 4'h3];
		endcase
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			c_r <= 8'h00;
			pos_r <= 4'h0;
			ph_r <= 2'h0;
			fa_r <= 1'b0;
		end
		else
		begin
			ph_r <= ph_r + 2'h1;
			c_r <= (c_r == 8'h9f) ? 8'h00 : c_r + 8'h01;
			if (c_r == 8'h9f)
			begin
				pos_r <= (pos_r == 4'h8) ? 4'h0 : pos_r + 4'h1;
				if (pos_r == 4'h8 && !bad)
					fa_r <= ~fa_r;
			end
		end
	end
endmodule

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the demultiplexer.
// Assumes: Reference runs at four clocks a period.
// Notes:   The far end model frames the data.
`timescale 1ns/1ps
module testbench;
	logic       clk;
	logic       rst_n;
	logic       data;
	logic       ref_sq;
	logic [5:0] offhk;
	logic       trbl;
	logic       bad;
	logic       sync;
	logic [5:0] lamps;
	logic       busy;
	logic       dist_n;
	logic       loss;
	logic       strobe;
	logic [7:0] loss_cnt = 8'h00;
	logic [7:0] strobe_cnt = 8'h00;
	int         failures;
	int         samples_checked;
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	sdm_far_end far_u (.clk(clk), .rst_n(rst_n), .offhk(offhk), .trbl(trbl), .bad(bad), .data(data), .ref_sq(ref_sq));
	sdm_demux dut_u (.clk(clk), .rst_n(rst_n), .binary_train_lead(data), .ref_square(ref_sq),
		.sync_indicator(sync), .trunk_state_indicators(lamps), .trunk_busy(busy), .sync_loss_pulse(loss),
		.sample_strobe(strobe), .distortion_data_n(dist_n));
	task automatic cmp_flag(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t flag %b not %b", $time, got, exp);
		end
	endtask
	task automatic cmp_lamps(input logic [5:0] got, input logic [5:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t lamps %h not %h", $time, got, exp);
		end
	endtask
	always @(negedge clk)
	begin
		if (strobe === 1'b1)
			strobe_cnt <= strobe_cnt + 8'h01;
		if (loss === 1'b1)
			loss_cnt <= loss_cnt + 8'h01;
	end
	task automatic cmp_count(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t count %0d not %0d", $time, got, exp);
		end
	endtask
	task automatic wait_for(input logic lvl);
		int n;
		n = 0;
		while (sync !== lvl && n < 20000)
		begin
			@(posedge clk);
			#2;
			n++;
		end
	endtask
	task automatic frames(input int k);
		repeat (k * 1440) @(posedge clk);
		#2;
	endtask
	task automatic t_acquire;
		logic [7:0] s0;
		wait_for(1'b1);
		cmp_flag(sync, 1'b1);
		s0 = strobe_cnt;
		frames(2);
		cmp_count(strobe_cnt - s0, 8'h0c);
		cmp_lamps(lamps, ~6'h2c);
		cmp_flag(busy, 1'b0);
		$display("acquire done");
	endtask
	task automatic t_update;
		offhk = 6'h13;
		trbl = 1'b1;
		frames(2);
		cmp_lamps(lamps, ~6'h13);
		cmp_flag(busy, 1'b1);
		cmp_flag(sync, 1'b1);
		$display("update done");
	endtask
	task automatic t_loss;
		logic [7:0] s0;
		logic [7:0] s1;
		s0 = loss_cnt;
		bad = 1'b1;
		wait_for(1'b0);
		cmp_flag(sync, 1'b0);
		s1 = strobe_cnt;
		offhk = 6'h3f;
		frames(2);
		cmp_count(loss_cnt - s0, 8'h01);
		cmp_count(strobe_cnt - s1, 8'h00);
		cmp_lamps(lamps, ~6'h13);
		cmp_flag(sync, 1'b0);
		bad = 1'b0;
		wait_for(1'b1);
		cmp_flag(sync, 1'b1);
		frames(2);
		cmp_lamps(lamps, 6'h00);
		$display("loss done");
	endtask
	task automatic report_and_stop;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		#2000000;
		failures++;
		$display("[ERR] %0t timeout", $time);
		report_and_stop();
	end
	initial
	begin
		failures = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		offhk = 6'h2c;
		trbl = 1'b0;
		bad = 1'b0;
		repeat (3) @(posedge clk);
		#2;
		cmp_flag(sync, 1'b0);
		cmp_flag(dist_n, 1'b1);
		rst_n = 1'b1;
		t_acquire();
		t_update();
		t_loss();
		report_and_stop();
	end
endmodule
